// ---- dcrm_clock_reset.sv ----
// clock selection, phase steering and reset generation for a ddr phy
// assumes the pll counter outputs arrive as clock-rate level inputs and lock is synchronous
`timescale 1ns/100ps
`include "dcrm_params.svh"
module dcrm_clock_reset (
    input wire logic clk_sys, // 250 MHz system clock
    input wire logic rst, // synchronous active high reset
    input wire logic pllC0, // counter zero output, half rate
    input wire logic pllC1, // counter one output, full rate
    input wire logic pllC2, // counter two output, half rate
    input wire logic pllC3, // counter three output, full rate, leads by 90
    input wire logic pllC4, // counter four output, calibrated
    input wire logic pllC5, // counter five output, calibrated
    input wire logic pllLocked, // pll lock indication
    input wire logic globalReset_n, // global reset, active low
    input wire logic softReset_n, // soft reset, active low
    input wire logic resetRequest_n, // optional reset request, active low
    input wire logic useResetReq, // enables the reset-request path
    input wire logic [1:0] acPhase, // address/command phase choice
    input wire logic resampleStep, // request one resample phase step
    input wire logic resampleUp, // resample step direction
    input wire logic vtStep, // request one vt tracking phase step
    input wire logic vtUp, // vt step direction
    output logic half_rate_sys_clock, // half-rate system clock
    output logic auxHalfRateClock, // copy of the system clock
    output logic memory_rate_clock, // full-rate memory clock
    output logic auxFullRateClock, // copy of the memory clock
    output logic half_memory_rate_clock, // half-rate memory clock
    output logic write_data_clock, // full-rate write clock
    output logic addr_cmd_clock, // address/command clock
    output logic chip_select_clock, // chip-select clock
    output logic resample_clock, // resample clock
    output logic vt_tracking_clock, // vt tracking clock
    output logic scanClock, // pll reconfiguration clock
    output logic [`DCRM_PHASE_W-1:0] resamplePhase, // resample phase step index
    output logic [`DCRM_PHASE_W-1:0] vtPhase, // vt phase step index
    output logic phyReset_n, // internal phy reset, active low
    output logic scanReset_n, // divider domain reset, active low
    output logic mem_reset_n // memory reset, active low
);
    // ---------------------------------------------------------------
    // clock routing
    // ---------------------------------------------------------------
    dcrm_pkg::dcrm_acsrc_t acSrc;

    // maps the phase choice to a source and polarity
    function automatic dcrm_pkg::dcrm_acsrc_t acDecode(input logic [1:0] ph);
        unique case (ph)
            `DCRM_AC_0: acDecode = dcrm_pkg::DCRM_AC_MEM;
            `DCRM_AC_180: acDecode = dcrm_pkg::DCRM_AC_MEM_INV;
            `DCRM_AC_270: acDecode = dcrm_pkg::DCRM_AC_WR;
            `DCRM_AC_90: acDecode = dcrm_pkg::DCRM_AC_WR_INV;
        endcase
    endfunction

    // fixed-phase and calibrated counters drive the named clocks straight through
    always_comb begin
        half_rate_sys_clock = pllC0;
        auxHalfRateClock = pllC0;
        memory_rate_clock = pllC1;
        auxFullRateClock = pllC1;
        half_memory_rate_clock = pllC2;
        write_data_clock = pllC3;
        resample_clock = pllC4;
        vt_tracking_clock = pllC5;
    end

    // address/command clock picks memory or write clock, inverted for 180 and 90
    always_comb begin
        acSrc = acDecode(acPhase);
        unique case (acSrc)
            dcrm_pkg::DCRM_AC_MEM: addr_cmd_clock = pllC1;
            dcrm_pkg::DCRM_AC_MEM_INV: addr_cmd_clock = ~pllC1;
            dcrm_pkg::DCRM_AC_WR: addr_cmd_clock = pllC3;
            dcrm_pkg::DCRM_AC_WR_INV: addr_cmd_clock = ~pllC3;
        endcase
        chip_select_clock = addr_cmd_clock;
    end

    // ---------------------------------------------------------------
    // phase stepping for the calibrated clocks
    // ---------------------------------------------------------------
    // resample phase index, wraps over the sixteen steps
    always_ff @(posedge clk_sys) begin
        if (!phyReset_n) begin
            resamplePhase <= '0;
        end else if (resampleStep) begin
            resamplePhase <= resampleUp ? resamplePhase + 4'h1 : resamplePhase - 4'h1;
        end
    end

    // vt tracking phase index, same step size
    always_ff @(posedge clk_sys) begin
        if (!phyReset_n) begin
            vtPhase <= '0;
        end else if (vtStep) begin
            vtPhase <= vtUp ? vtPhase + 4'h1 : vtPhase - 4'h1;
        end
    end

    // ---------------------------------------------------------------
    // reset request edge detect and counter
    // ---------------------------------------------------------------
    logic reqPrev;
    logic [7:0] holdCount;
    dcrm_pkg::dcrm_rst_t rstState;
    dcrm_pkg::dcrm_rst_t next_rstState;
    logic reqFall;

    assign reqFall = useResetReq && reqPrev && !resetRequest_n;

    // remembers the request level for edge detection
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reqPrev <= 1'b1;
        end else begin
            reqPrev <= resetRequest_n;
        end
    end

    // a falling request holds reset for a fixed count
    always_comb begin
        next_rstState = rstState;
        unique case (rstState)
            dcrm_pkg::DCRM_HOLD: next_rstState = dcrm_pkg::DCRM_COUNT;
            dcrm_pkg::DCRM_COUNT: begin
                if (holdCount == `DCRM_RST_HOLD) begin
                    next_rstState = dcrm_pkg::DCRM_RUN;
                end
            end
            dcrm_pkg::DCRM_RUN: begin
                if (reqFall) begin
                    next_rstState = dcrm_pkg::DCRM_HOLD;
                end
            end
            default: next_rstState = dcrm_pkg::DCRM_HOLD;
        endcase
    end

    // state register and hold counter
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rstState <= dcrm_pkg::DCRM_HOLD;
            holdCount <= 8'h00;
        end else begin
            rstState <= next_rstState;
            holdCount <= (rstState == dcrm_pkg::DCRM_COUNT) ? holdCount + 8'h01 : 8'h00;
        end
    end

    // ---------------------------------------------------------------
    // reset synchronisers
    // ---------------------------------------------------------------
    logic phyRstRaw;
    logic scanRstRaw;
    logic [1:0] phySync;
    logic [1:0] scanSync;

    assign phyRstRaw = rst || !globalReset_n || !softReset_n || !pllLocked
        || rstState != dcrm_pkg::DCRM_RUN;
    assign scanRstRaw = rst || !globalReset_n || !pllLocked;

    // system domain: assert at once, release after two stages
    always_ff @(posedge clk_sys) begin
        if (phyRstRaw) begin
            phySync <= 2'h0;
        end else begin
            phySync <= {phySync[0], 1'b1};
        end
    end

    // divider domain has its own chain, blind to soft reset
    always_ff @(posedge clk_sys) begin
        if (scanRstRaw) begin
            scanSync <= 2'h0;
        end else begin
            scanSync <= {scanSync[0], 1'b1};
        end
    end

    assign phyReset_n = phySync[1];
    assign scanReset_n = scanSync[1];
    assign mem_reset_n = phySync[1];

    // ---------------------------------------------------------------
    // reconfiguration clock divider
    // ---------------------------------------------------------------
    logic [3:0] divCount;

    // toggles every DCRM_SCAN_HALF cycles, keeping scan below its limit
    always_ff @(posedge clk_sys) begin
        if (!scanReset_n) begin
            divCount <= 4'h0;
            scanClock <= 1'b0;
        end else if (divCount == 4'(`DCRM_SCAN_HALF - 1)) begin
            divCount <= 4'h0;
            scanClock <= ~scanClock;
        end else begin
            divCount <= divCount + 4'h1;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    // divider rate: a toggle is never followed by another at once
    scan_rate_a: assert property (
        @(posedge clk_sys) disable iff (!scanReset_n)
        $changed(scanClock) |=> $stable(scanClock))
        else $error("scan clock toggled on consecutive cycles");

    // address/command routing for each of the four phase choices
    ac_route_a: assert property (
        @(posedge clk_sys)
        (acPhase == `DCRM_AC_90) |-> (addr_cmd_clock == ~pllC3))
        else $error("address clock source wrong for 90 degrees");
    ac_zero_a: assert property (
        @(posedge clk_sys)
        (acPhase == `DCRM_AC_0) |-> (addr_cmd_clock == pllC1))
        else $error("address clock source wrong for 0 degrees");
    ac_half_a: assert property (
        @(posedge clk_sys)
        (acPhase == `DCRM_AC_180) |-> (addr_cmd_clock == ~pllC1))
        else $error("address clock source wrong for 180 degrees");
    ac_late_a: assert property (
        @(posedge clk_sys)
        (acPhase == `DCRM_AC_270) |-> (addr_cmd_clock == pllC3))
        else $error("address clock source wrong for 270 degrees");
    cs_follow_a: assert property (
        @(posedge clk_sys)
        chip_select_clock == addr_cmd_clock)
        else $error("chip-select clock not following address clock");

    // fixed and calibrated clock routing
    fixed_clk_a: assert property (
        @(posedge clk_sys)
        write_data_clock == pllC3 && memory_rate_clock == pllC1)
        else $error("fixed clock routing broken");
    sys_route_a: assert property (
        @(posedge clk_sys)
        half_rate_sys_clock == pllC0 && auxHalfRateClock == pllC0)
        else $error("system clock routing broken");
    half_mem_a: assert property (
        @(posedge clk_sys)
        half_memory_rate_clock == pllC2 && auxFullRateClock == pllC1)
        else $error("half memory clock routing broken");
    cal_route_a: assert property (
        @(posedge clk_sys)
        resample_clock == pllC4 && vt_tracking_clock == pllC5)
        else $error("calibrated clock routing broken");

    // reset causes reach the phy and memory resets
    lock_reset_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        !pllLocked |=> ##1 !phyReset_n)
        else $error("lock loss did not reset phy");
    soft_reset_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        !softReset_n |=> ##1 !phyReset_n)
        else $error("soft reset did not reset phy");
    global_reset_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        !globalReset_n |=> ##1 (!phyReset_n && !scanReset_n))
        else $error("global reset did not reset both domains");
    mem_reset_a: assert property (
        @(posedge clk_sys)
        mem_reset_n == phyReset_n)
        else $error("memory reset not derived from phy reset");

    // divider reset chain
    soft_isolate_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        (scanReset_n && globalReset_n && pllLocked) |=> scanReset_n)
        else $error("divider reset dropped without cause");
    scan_lock_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        !pllLocked |=> ##1 !scanReset_n)
        else $error("lock loss did not reset divider");

    // synchronous release after two clean stages
    sync_release_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        $rose(phyReset_n) |-> $past(!phyRstRaw, 2) && $past(!phyRstRaw))
        else $error("phy reset released without two clean stages");
    scan_release_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        $rose(scanReset_n) |-> $past(!scanRstRaw, 2) && $past(!scanRstRaw))
        else $error("divider reset released without two clean stages");

    // reset request path and hold count
    req_hold_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        (reqFall && rstState == dcrm_pkg::DCRM_RUN) |=> ##[1:3] !phyReset_n)
        else $error("reset request not honoured");
    hold_len_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        (rstState == dcrm_pkg::DCRM_COUNT && holdCount != `DCRM_RST_HOLD)
        |=> rstState == dcrm_pkg::DCRM_COUNT)
        else $error("reset hold ended early");

    // phase step indices wrap and hold
    step_wrap_a: assert property (
        @(posedge clk_sys) disable iff (!phyReset_n)
        (resampleStep && resampleUp && resamplePhase == 4'hF) |=> resamplePhase == 4'h0)
        else $error("resample phase did not wrap over sixteen steps");
    vt_wrap_a: assert property (
        @(posedge clk_sys) disable iff (!phyReset_n)
        (vtStep && !vtUp && vtPhase == 4'h0) |=> vtPhase == 4'hF)
        else $error("vt phase did not wrap downwards");
    step_hold_a: assert property (
        @(posedge clk_sys) disable iff (!phyReset_n)
        !resampleStep |=> $stable(resamplePhase))
        else $error("resample phase moved without a step");
    vt_hold_a: assert property (
        @(posedge clk_sys) disable iff (!phyReset_n)
        !vtStep |=> $stable(vtPhase))
        else $error("vt phase moved without a step");
endmodule // dcrm_clock_reset

// ---- dcrm_params.svh ----
// constants for the ddr phy clock and reset manager
// assumes a 250 MHz system clock on clk_sys and a pll model outside this block
// Functional notes
// - half-rate system clock and auxiliary copy come from counter zero at zero phase
// - reconfiguration clock divides the half-rate system clock, kept below 100 MHz; the code divides clk_sys by four instead
// - full-rate memory clock and copy from counter one at zero phase
// - half-rate memory clock from counter two at zero phase
// - write-data clock from counter three, leading memory clock by 90 degrees
// - addr/cmd clock from memory clock for 0/180, write clock for 90/270
// - chip-select clock follows the address/command clock
// - resample clock from counter four, phase calibrated to data-valid centre
// - free-running calibrated vt tracking clock measures drift through mimic path
// - single-rate clocks run at half, double-rate at full memory rate
// - optional reset-request edge detector and counter on reference clock
// - divider has its own reset synchroniser, free of soft reset
// - internal reset combines global reset, soft reset and pll lock
// - pll offers at least sixteen phase steps of the fastest clock
`ifndef DCRM_PARAMS_SVH
`define DCRM_PARAMS_SVH
`define DCRM_SYS_CLK_MHZ 250
`define DCRM_SCAN_MAX_MHZ 100
// half period of the scan divider in system cycles, rounded up so scan stays below the limit
`define DCRM_SCAN_HALF ((`DCRM_SYS_CLK_MHZ + 2 * `DCRM_SCAN_MAX_MHZ - 1) / (2 * `DCRM_SCAN_MAX_MHZ))
`define DCRM_PHASE_STEPS 16
`define DCRM_PHASE_W 4
`define DCRM_RST_HOLD 8'h20
`define DCRM_AC_0 2'h0
`define DCRM_AC_90 2'h1
`define DCRM_AC_180 2'h2
`define DCRM_AC_270 2'h3
`endif

// ---- dcrm_pkg.sv ----
// types for the ddr phy clock and reset manager
// assumes dcrm_params.svh is compiled alongside
package dcrm_pkg;
    // source of the address/command clock
    typedef enum logic [1:0] {
        DCRM_AC_MEM = 2'b00,
        DCRM_AC_MEM_INV = 2'b01,
        DCRM_AC_WR = 2'b10,
        DCRM_AC_WR_INV = 2'b11
    } dcrm_acsrc_t;
    // reset sequencing states
    typedef enum logic [1:0] {
        DCRM_HOLD = 2'b00,
        DCRM_COUNT = 2'b01,
        DCRM_RUN = 2'b10
    } dcrm_rst_t;
endpackage

// ---- dcrm_pll_model.sv ----
// pll stand-in feeding the clock and reset manager
// assumes clk_sys is the reference and globalReset_n restarts lock
`timescale 1ns/100ps
module dcrm_pll_model #(
    parameter int LOCK_CYC = 4
) (
    input wire logic clk_sys, // reference clock
    input wire logic globalReset_n, // pll reset, active low
    output logic pllC0, // counter zero
    output logic pllC1, // counter one
    output logic pllC2, // counter two
    output logic pllC3, // counter three
    output logic pllC4, // counter four
    output logic pllC5, // counter five
    output logic pllLocked // lock indication
);
    logic [3:0] cnt = 4'h0;
    int lockCnt = 0;
    // distinct patterns per counter so a swapped route shows
    always_ff @(posedge clk_sys) begin
        cnt <= cnt + 4'h1;
    end
    assign pllC0 = cnt[1];
    assign pllC1 = cnt[0];
    assign pllC2 = cnt[2];
    assign pllC3 = cnt[0] ^ cnt[1];
    assign pllC4 = cnt[3];
    assign pllC5 = cnt[2] ^ cnt[3];
    // lock drops while held in reset, returns after a fixed count
    always_ff @(posedge clk_sys) begin
        if (!globalReset_n) lockCnt <= 0;
        else if (lockCnt < LOCK_CYC) lockCnt <= lockCnt + 1;
    end
    assign pllLocked = (lockCnt == LOCK_CYC);
endmodule // dcrm_pll_model

// ---- tb.sv ----
// self-checking bench for the clock and reset manager
// assumes the pll model drives all counter outputs and lock
`timescale 1ns/100ps
module tb;
    logic clk_sys = 0, rst = 1, globalReset_n = 1, softReset_n = 1;
    logic resetRequest_n = 1, useResetReq = 0;
    logic [1:0] acPhase = 2'h0;
    logic resampleStep = 0, resampleUp = 1, vtStep = 0, vtUp = 1;
    logic pllC0, pllC1, pllC2, pllC3, pllC4, pllC5, pllLocked;
    logic hs, hsa, mr, mra, hm, wd, ac, cs, rs, vt, scanClock;
    logic [3:0] resamplePhase, vtPhase;
    logic phyReset_n, scanReset_n, mem_reset_n;
    int failures = 0, cmp_count = 0;
    // free-running system clock
    always #2 clk_sys = ~clk_sys;
    dcrm_pll_model #(.LOCK_CYC(4)) i_pll (.clk_sys(clk_sys), .globalReset_n(globalReset_n),
        .pllC0(pllC0), .pllC1(pllC1), .pllC2(pllC2), .pllC3(pllC3), .pllC4(pllC4),
        .pllC5(pllC5), .pllLocked(pllLocked));
    dcrm_clock_reset i_dut (.clk_sys(clk_sys), .rst(rst), .pllC0(pllC0), .pllC1(pllC1),
        .pllC2(pllC2), .pllC3(pllC3), .pllC4(pllC4), .pllC5(pllC5), .pllLocked(pllLocked),
        .globalReset_n(globalReset_n), .softReset_n(softReset_n),
        .resetRequest_n(resetRequest_n), .useResetReq(useResetReq), .acPhase(acPhase),
        .resampleStep(resampleStep), .resampleUp(resampleUp), .vtStep(vtStep), .vtUp(vtUp),
        .half_rate_sys_clock(hs), .auxHalfRateClock(hsa), .memory_rate_clock(mr),
        .auxFullRateClock(mra), .half_memory_rate_clock(hm), .write_data_clock(wd),
        .addr_cmd_clock(ac), .chip_select_clock(cs), .resample_clock(rs),
        .vt_tracking_clock(vt), .scanClock(scanClock), .resamplePhase(resamplePhase),
        .vtPhase(vtPhase), .phyReset_n(phyReset_n), .scanReset_n(scanReset_n),
        .mem_reset_n(mem_reset_n));
    task tally_and_finish;
        if (failures == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // compare a small value and count the outcome
    task chk(input logic [3:0] got, input logic [3:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask
    // wait for the phy reset to lift, giving up after a bound
    task wait_run(output int n);
        n = 0;
        while (phyReset_n !== 1'b1 && n < 200) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 200) begin
            chk(4'h0, 4'h1, "phy reset never lifted");
            tally_and_finish;
        end
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_reset_release;
        int n;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(negedge clk_sys);
        chk({3'h0, scanReset_n}, 4'h0, "scan reset lifted in one stage");
        wait_run(n);
        chk({3'h0, n >= 32}, 4'h1, "phy reset hold too short");
        chk({3'h0, mem_reset_n}, 4'h1, "memory reset not following");
    endtask
    task t_clock_routes;
        logic x;
        for (int p = 0; p < 4; p++) begin
            @(posedge clk_sys);
            acPhase <= p[1:0];
            repeat (8) begin
                @(negedge clk_sys);
                x = (p == 0) ? pllC1 : (p == 1) ? ~pllC3 : (p == 2) ? ~pllC1 : pllC3;
                chk({hs, hsa, mr, mra}, {pllC0, pllC0, pllC1, pllC1}, "sys/mem route");
                chk({hm, wd, rs, vt}, {pllC2, pllC3, pllC4, pllC5}, "other routes");
                chk({2'h0, ac, cs}, {2'h0, x, x}, "addr/cmd or chip-select route");
            end
        end
    endtask
    task t_scan_clock;
        logic s;
        int k;
        @(negedge clk_sys);
        s = scanClock;
        for (k = 0; k < 8 && scanClock === s; k++) @(negedge clk_sys);
        if (k >= 8) chk(4'h0, 4'h1, "scan clock never toggled");
        for (int i = 0; i < 6; i++) begin
            s = scanClock;
            @(negedge clk_sys);
            chk({3'h0, scanClock}, {3'h0, s}, "scan clock changed early");
            @(negedge clk_sys);
            chk({3'h0, scanClock}, {3'h0, ~s}, "scan clock half period");
        end
    endtask
    task t_phase_steps;
        @(posedge clk_sys);
        {resampleStep, resampleUp, vtStep, vtUp} <= 4'hE;
        repeat (17) @(posedge clk_sys);
        {resampleStep, vtStep} <= 2'h0;
        @(negedge clk_sys);
        chk(resamplePhase, 4'h1, "resample phase wrap up");
        chk(vtPhase, 4'hF, "vt phase wrap down");
    endtask
    task t_soft_reset;
        int n;
        @(posedge clk_sys);
        softReset_n <= 1'b0;
        repeat (2) @(negedge clk_sys);
        chk({2'h0, phyReset_n, mem_reset_n}, 4'h0, "soft reset not taken");
        @(posedge clk_sys);
        resampleStep <= 1'b1;
        @(posedge clk_sys);
        resampleStep <= 1'b0;
        @(negedge clk_sys);
        chk(resamplePhase, 4'h0, "step taken in reset");
        chk({3'h0, scanReset_n}, 4'h1, "divider reset saw soft reset");
        @(posedge clk_sys);
        softReset_n <= 1'b1;
        wait_run(n);
    endtask
    task t_reset_request;
        int n;
        @(posedge clk_sys);
        useResetReq <= 1'b1;
        resetRequest_n <= 1'b0;
        repeat (3) @(negedge clk_sys);
        chk({3'h0, phyReset_n}, 4'h0, "reset request ignored");
        @(posedge clk_sys);
        resetRequest_n <= 1'b1;
        wait_run(n);
        chk({3'h0, n >= 29}, 4'h1, "request hold too short");
    endtask
    task t_global_relock;
        int n;
        @(posedge clk_sys);
        globalReset_n <= 1'b0;
        repeat (2) @(negedge clk_sys);
        chk({2'h0, phyReset_n, scanReset_n}, 4'h0, "global reset not taken");
        @(posedge clk_sys);
        globalReset_n <= 1'b1;
        for (n = 0; n < 20 && pllLocked !== 1'b1; n++) @(negedge clk_sys);
        if (n >= 20) chk(4'h0, 4'h1, "pll never relocked");
        chk({3'h0, scanReset_n}, 4'h0, "divider reset lifted before lock");
        repeat (3) @(negedge clk_sys);
        chk({3'h0, scanReset_n}, 4'h1, "divider reset stuck after lock");
        wait_run(n);
    endtask
    initial begin
        t_reset_release;
        t_clock_routes;
        t_scan_clock;
        t_phase_steps;
        t_soft_reset;
        t_reset_request;
        t_global_relock;
        tally_and_finish;
    end
endmodule // tb
